// ### hdl/tps_cfg.svh
// offsets, field positions, reset values and divider codes
// assumes a 32-bit apb word per register, index times four
`ifndef TPS_CFG_SVH
`define TPS_CFG_SVH
`define TPS_IDX_MODE0 20'hF0190
`define TPS_IDX_MODE1 20'hF0192
`define TPS_IDX_MODE2 20'hF0194
`define TPS_IDX_MODE3 20'hF0196
`define TPS_IDX_PRESC 20'hF01B6
`define TPS_IDX_RUN 20'hF01C0
`define TPS_IDX_STAT 20'hF01C2
`define TPS_RST_PRESC 16'h0000
`define TPS_RST_MODE 16'h0000
`define TPS_RST_RUN 4'h0
`define TPS_PRESC_WMASK 16'h33FF
`define TPS_MODE_WMASK 16'hDFCF
`define TPS_MODE0_WMASK 16'hD7CF
`define TPS_FA_LSB 0
`define TPS_FB_LSB 4
`define TPS_FC_LSB 8
`define TPS_FD_LSB 12
`define TPS_COARSE_CH 4'hA
`define TPS_EXP_C0 4'h1
`define TPS_EXP_C1 4'h2
`define TPS_EXP_C2 4'h4
`define TPS_EXP_C3 4'h6
`define TPS_EXP_D0 4'h8
`define TPS_EXP_D1 4'hA
`define TPS_EXP_D2 4'hC
`define TPS_EXP_D3 4'hE
`define TPS_DIV_W 15
`endif

// ### hdl/tps_clk_sel.sv
// timer prescaler and per-channel operation clock selection
// assumes an apb master on pclk; pins synchronous to pclk
//
// Overview of operation
// - clocks a and b are fclk over two to the power of nibble fields.
// - clock c divides fclk by 2, 4, 16 or 64 per 2-bit code.
// - clock d divides fclk by 256, 1024, 4096 or 16384 per code.
// - each divided clock is a one-cycle enable pulse, not a square wave.
// - undivided clock with zero compare value hides channel interrupts.
// - reset clears prescaler select and all mode registers to zero.
// - select code 00 picks a, 01 c, 10 b, 11 d.
// - clocks c and d reachable only from channels 1 and 3.
// - selected clock feeds edge detector; count source bit picks tick.
// - source bit 0 counts operation clock, 1 counts input edges.
// - bit 11 is master on ch2, split on ch1 and 3, zero on ch0.
//
// Added by the designer: register access over APB.
`include "tps_cfg.svh"
`timescale 1ns/1ns
module tps_clk_sel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] timer_input_pin,
  input wire logic [3:0] chan_irq_raw,
  input wire logic [63:0] channel_compare_value,
  output logic [3:0] shared_op_clock,
  output logic [3:0] chan_op_clock,
  output logic [3:0] count_tick,
  output logic [3:0] chan_irq_det,
  output logic [3:0] channel_enabled_flag,
  output logic master_role_sel,
  output logic [1:0] eight_bit_split_sel
);
  logic [15:0] presc_q;
  tps_pkg::tps_mode_s mode_q [4];
  logic [3:0] run_q;
  logic [`TPS_DIV_W-1:0] cnt_q;
  logic [3:0] op_q;
  logic [3:0] op_d;
  logic [31:0] prdata_q;
  logic [3:0] pin_q;
  logic [3:0] tick_q;
  logic [3:0] chop_q;
  logic [3:0] irq_q;
  logic [3:0] sup;
  logic [1:0] eff_sel [4];
  tps_pkg::tps_exp_t exp_c;
  tps_pkg::tps_exp_t exp_d;
  logic [3:0] coarse_ok;
  logic hit_mode [4];
  logic hit_presc;
  logic hit_run;
  logic hit_stat;
  logic hit_any;
  logic wr_en;

  // true once every 2^k cycles, aligned to the shared divider
  function automatic logic div_pulse(
    input logic [`TPS_DIV_W-1:0] cnt,
    input tps_pkg::tps_exp_t k
  );
    logic [`TPS_DIV_W-1:0] mask;
    mask = `TPS_DIV_W'((16'h0001 << k) - 16'h0001);
    div_pulse = &(cnt | ~mask);
  endfunction

  // address decode: each register sits at four times its index
  assign hit_mode[0] = paddr == {10'h000, `TPS_IDX_MODE0, 2'h0};
  assign hit_mode[1] = paddr == {10'h000, `TPS_IDX_MODE1, 2'h0};
  assign hit_mode[2] = paddr == {10'h000, `TPS_IDX_MODE2, 2'h0};
  assign hit_mode[3] = paddr == {10'h000, `TPS_IDX_MODE3, 2'h0};
  assign hit_presc = paddr == {10'h000, `TPS_IDX_PRESC, 2'h0};
  assign hit_run = paddr == {10'h000, `TPS_IDX_RUN, 2'h0};
  assign hit_stat = paddr == {10'h000, `TPS_IDX_STAT, 2'h0};
  assign hit_any = hit_mode[0] | hit_mode[1] | hit_mode[2]
    | hit_mode[3] | hit_presc | hit_run | hit_stat;
  // zero wait state; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign wr_en = psel & penable & pwrite & hit_any;
  assign prdata = prdata_q;

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= 32'h0000_0000;
      if (hit_presc) prdata_q <= {16'h0000, presc_q};
      if (hit_run) prdata_q <= {28'h0000000, run_q};
      if (hit_stat) prdata_q <= {13'h0000, op_q, cnt_q};
      for (int i = 0; i < 4; i++) begin
        if (hit_mode[i]) prdata_q <= {16'h0000, mode_q[i]};
      end
    end
  end

  // reserved bits dropped on write and read back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= `TPS_RST_PRESC;
    end else if (wr_en && hit_presc) begin
      presc_q <= pwdata[15:0] & `TPS_PRESC_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= `TPS_RST_RUN;
    end else if (wr_en && hit_run) begin
      run_q <= pwdata[3:0];
    end
  end
  assign channel_enabled_flag = run_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + `TPS_DIV_W'(1);
    end
  end

  // coarse exponents for the two-bit fields
  always_comb begin
    case (presc_q[`TPS_FC_LSB +: 2])
      2'h0: exp_c = `TPS_EXP_C0;
      2'h1: exp_c = `TPS_EXP_C1;
      2'h2: exp_c = `TPS_EXP_C2;
      default: exp_c = `TPS_EXP_C3;
    endcase
    case (presc_q[`TPS_FD_LSB +: 2])
      2'h0: exp_d = `TPS_EXP_D0;
      2'h1: exp_d = `TPS_EXP_D1;
      2'h2: exp_d = `TPS_EXP_D2;
      default: exp_d = `TPS_EXP_D3;
    endcase
  end

  assign op_d[0] = div_pulse(cnt_q, presc_q[`TPS_FA_LSB +: 4]);
  assign op_d[1] = div_pulse(cnt_q, presc_q[`TPS_FB_LSB +: 4]);
  assign op_d[2] = div_pulse(cnt_q, exp_c);
  assign op_d[3] = div_pulse(cnt_q, exp_d);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= 4'h0;
    end else begin
      op_q <= op_d;
    end
  end
  assign shared_op_clock = op_q;

  // coarse clocks only reach channels 1 and 3; the rest fold onto a and b
  assign coarse_ok = `TPS_COARSE_CH;

  genvar n;
  generate
    for (n = 0; n < 4; n++) begin : g_ch
      logic fmck;
      logic edge_hit;
      logic rise;
      logic fall;
      logic [15:0] cmp;
      logic [15:0] wmask;
      assign wmask = (n == 0) ? `TPS_MODE0_WMASK : `TPS_MODE_WMASK;
      assign cmp = channel_compare_value[16*n +: 16];

      // channel 0 bit 11 is write-ignored zero
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mode_q[n] <= `TPS_RST_MODE;
        end else if (wr_en && hit_mode[n]) begin
          mode_q[n] <= pwdata[15:0] & wmask;
        end
      end

      // channels 0 and 2 lose the coarse clocks
      assign eff_sel[n] = {mode_q[n].op_clock_sel[1],
        mode_q[n].op_clock_sel[0] & coarse_ok[n]};
      // code 01 maps to c, 10 maps to b
      assign fmck = op_q[{eff_sel[n][0], eff_sel[n][1]}];

      // pin sampled on the operation clock
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_q[n] <= 1'b0;
        end else if (fmck) begin
          pin_q[n] <= timer_input_pin[n];
        end
      end
      assign rise = fmck & timer_input_pin[n] & ~pin_q[n];
      assign fall = fmck & ~timer_input_pin[n] & pin_q[n];
      always_comb begin
        case (tps_pkg::tps_edge_e'(mode_q[n].input_edge_sel))
          tps_pkg::TPS_EDGE_FALL: edge_hit = fall;
          tps_pkg::TPS_EDGE_RISE: edge_hit = rise;
          default: edge_hit = rise | fall;
        endcase
      end

      // count source select, gated by channel enable
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tick_q[n] <= 1'b0;
          chop_q[n] <= 1'b0;
        end else begin
          tick_q[n] <= run_q[n] & (mode_q[n].count_clock_source_sel
            ? edge_hit : fmck);
          chop_q[n] <= fmck;
        end
      end

      // undivided clock with zero compare hides requests
      assign sup[n] = (cmp == 16'h0000) &&
        ((eff_sel[n] == 2'h0 && presc_q[`TPS_FA_LSB +: 4] == 4'h0) ||
         (eff_sel[n] == 2'h2 && presc_q[`TPS_FB_LSB +: 4] == 4'h0));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_q[n] <= 1'b0;
        end else begin
          irq_q[n] <= chan_irq_raw[n] & ~sup[n];
        end
      end
    end
  endgenerate

  assign count_tick = tick_q;
  assign chan_op_clock = chop_q;
  assign chan_irq_det = irq_q;
  assign master_role_sel = mode_q[2].bit11;
  assign eight_bit_split_sel = {mode_q[3].bit11, mode_q[1].bit11};

  sequence s_gap1(int b);
    !op_q[b] ##1 op_q[b];
  endsequence

  a_fine_a_period: assert property (@(posedge pclk) disable iff (!presetn)
    (op_q[0] && presc_q[3:0] == 4'h1 && $stable(presc_q))
      ##1 (presc_q[3:0] == 4'h1) |-> s_gap1(0))
    else $error("clock a period wrong for divide by two");
  a_coarse_c_fast: assert property (@(posedge pclk) disable iff (!presetn)
    (op_q[2] && presc_q[9:8] == 2'h0 && $stable(presc_q))
      ##1 (presc_q[9:8] == 2'h0) |-> s_gap1(2))
    else $error("clock c period wrong for code zero");
  a_coarse_d_align: assert property (@(posedge pclk) disable iff (!presetn)
    op_q[3] |-> cnt_q[7:0] == 8'h00)
    else $error("clock d pulse not aligned to divider");
  a_pulse_single: assert property (@(posedge pclk) disable iff (!presetn)
    (op_q[1] && presc_q[7:4] != 4'h0 && $stable(presc_q)) |=> !op_q[1])
    else $error("divided clock b held longer than one cycle");
  a_reset_zero: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> presc_q == 16'h0000 && mode_q[3] == 16'h0000)
    else $error("registers not cleared by reset");
  a_ch0_no_coarse: assert property (@(posedge pclk) disable iff (!presetn)
    (eff_sel[0][0] == 1'b0) && (eff_sel[2][0] == 1'b0))
    else $error("channel 0 or 2 reached a coarse clock");
  a_irq_hidden: assert property (@(posedge pclk) disable iff (!presetn)
    (sup[0] && chan_irq_raw[0]) |=> !chan_irq_det[0])
    else $error("interrupt passed with undivided clock and zero compare");
  a_tick_opclk: assert property (@(posedge pclk) disable iff (!presetn)
    (run_q[0] && !mode_q[0].count_clock_source_sel
      && mode_q[0].op_clock_sel == 2'h0 && op_q[0]) |=> count_tick[0])
    else $error("operation clock did not produce a count tick");
  a_ch0_bit11: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_mode[0]) |=> !mode_q[0].bit11)
    else $error("channel 0 bit 11 not held at zero");
  // selector checks; channel 2 folds code 11 onto clock b
  a_sel_fold_b: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q[2].op_clock_sel == 2'h3 |=> chan_op_clock[2] == $past(op_q[1]))
    else $error("channel 2 code 11 did not select clock b");
  a_sel_code_c: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q[3].op_clock_sel == 2'h1 |=> chan_op_clock[3] == $past(op_q[2]))
    else $error("channel 3 code 01 did not select clock c");
  a_split_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_mode[1]) |=> eight_bit_split_sel[0] == $past(pwdata[11]))
    else $error("channel 1 split bit not taken from bit 11");
  a_pin_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !op_q[{eff_sel[1][0], eff_sel[1][1]}] |=> $stable(pin_q[1]))
    else $error("pin sampled without the operation clock");
  a_irq_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (!sup[0] && chan_irq_raw[0]) |=> chan_irq_det[0])
    else $error("interrupt lost with a nonzero compare value");
endmodule // tps_clk_sel

// ### hdl/tps_pkg.sv
// types shared by the prescaler and clock-select block
// assumes tps_cfg.svh supplies the numeric constants
package tps_pkg;
  typedef struct packed {
    logic [1:0] op_clock_sel;
    logic rsv13;
    logic count_clock_source_sel;
    logic bit11;
    logic [2:0] trigger_source_sel;
    logic [1:0] input_edge_sel;
    logic [1:0] rsv54;
    logic [3:0] channel_op_mode_sel;
  } tps_mode_s;
  typedef enum logic [1:0] {
    TPS_EDGE_FALL = 2'h0,
    TPS_EDGE_RISE = 2'h1,
    TPS_EDGE_BOTH_L = 2'h2,
    TPS_EDGE_BOTH_H = 2'h3
  } tps_edge_e;
  typedef logic [3:0] tps_exp_t;
endpackage

// ### test/tps_clk_sel_tb.sv
// self-checking bench for the prescaler and clock select block
// assumes a zero-wait apb slave and one free-running divider
`include "tps_cfg.svh"
`timescale 1ns/1ns
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, err, master_role_sel;
  logic [3:0] timer_input_pin = '0, chan_irq_raw = '0;
  logic [63:0] channel_compare_value = '0;
  logic [3:0] shared_op_clock, chan_op_clock, count_tick, chan_irq_det;
  logic [3:0] channel_enabled_flag;
  logic [1:0] eight_bit_split_sel;
  int fail_count = 0, check_count = 0, r;
  int cexp[4] = '{1, 2, 4, 6};
  int dexp[4] = '{8, 10, 12, 14};
  int sel13[4] = '{1, 4, 2, 8};
  int sel02[4] = '{1, 1, 2, 2};
  logic [19:0] regs[5] = '{`TPS_IDX_MODE0, `TPS_IDX_MODE1,
    `TPS_IDX_MODE2, `TPS_IDX_MODE3, `TPS_IDX_PRESC};
  logic [15:0] masks[5] = '{16'hD7CF, 16'hDFCF, 16'hDFCF, 16'hDFCF,
    16'h33FF};

  always #20 pclk = ~pclk;

  tps_clk_sel tps_clk_sel_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_input_pin(timer_input_pin),
    .chan_irq_raw(chan_irq_raw),
    .channel_compare_value(channel_compare_value),
    .shared_op_clock(shared_op_clock), .chan_op_clock(chan_op_clock),
    .count_tick(count_tick), .chan_irq_det(chan_irq_det),
    .channel_enabled_flag(channel_enabled_flag),
    .master_role_sel(master_role_sel),
    .eight_bit_split_sel(eight_bit_split_sel));

  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task bound(input int c, input int lim);
    if (c >= lim) begin
      fail_count++;
      give_verdict;
    end
  endtask

  // whole-word writes only
  // request held until pready is sampled high at a rising edge
  task apb(input logic wr, input logic [19:0] idx, input logic [15:0] wd);
    int c;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= {10'h0, idx, 2'b00};
    pwdata <= {16'h0, wd};
    @(posedge pclk);
    penable <= 1;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (pready !== 1'b1 && c < 20);
    bound(c, 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  function logic pick(input int w);
    case (w / 4)
      0: return shared_op_clock[w % 4];
      1: return chan_op_clock[w % 4];
      default: return count_tick[w % 4];
    endcase
  endfunction

  // spacing between two pulses is the division ratio, phase free
  task gap(input int w, input int e);
    int c, lim;
    lim = (1 << e) + 4;
    // let a new setting reach the registered outputs first
    repeat (2) @(posedge pclk);
    c = 0;
    do begin
      @(negedge pclk);
      c++;
    end while (pick(w) !== 1'b1 && c < lim);
    bound(c, lim);
    c = 0;
    do begin
      @(negedge pclk);
      c++;
    end while (pick(w) !== 1'b1 && c < lim);
    chk("pulse gap", c, 1 << e);
  endtask

  initial begin
    r = $urandom(32'hc7d8);
    repeat (16) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 5; i++) begin
      apb(0, regs[i], 16'h0);
      chk("reset value", rd, 32'h0);
    end
    for (int i = 0; i < 5; i++) begin
      apb(1, regs[i], 16'hFFFF);
      apb(0, regs[i], 16'h0);
      chk("write mask", rd, {16'h0, masks[i]});
    end
    chk("master bit", master_role_sel, 1'b1);
    chk("split bits", eight_bit_split_sel, 2'b11);
    apb(0, 20'hF01A0, 16'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    for (int i = 0; i < 4; i++)
      apb(1, regs[i], 16'h0);
    // fine dividers, spacing of one-cycle pulses
    for (int k = 0; k < 10; k++) begin
      apb(1, `TPS_IDX_PRESC, k[15:0]);
      gap(0, k);
    end
    r = $urandom % 8;
    apb(1, `TPS_IDX_PRESC, 16'(r << 4));
    gap(1, r);
    // coarse codes on the shared divider
    for (int k = 0; k < 4; k++) begin
      apb(1, `TPS_IDX_PRESC, 16'((k << 8) | (k << 12)));
      gap(2, cexp[k]);
      gap(3, dexp[k]);
    end
    // selection per channel, run bit set after the write
    apb(1, `TPS_IDX_PRESC, 16'h0221);
    for (int ch = 0; ch < 4; ch++)
      for (int s = 0; s < 4; s++) begin
        apb(1, `TPS_IDX_RUN, 16'h0);
        apb(1, regs[ch], 16'(s << 14));
        apb(1, `TPS_IDX_RUN, 16'(1 << ch));
        r = (ch % 2) ? sel13[s] : sel02[s];
        gap(4 + ch, r);
        gap(8 + ch, r);
      end
    // input edges counted, rising edge selected
    apb(1, `TPS_IDX_RUN, 16'h0);
    apb(1, regs[1], 16'h1040);
    apb(1, `TPS_IDX_RUN, 16'h2);
    r = 0;
    repeat (20) @(negedge pclk) r += count_tick[1];
    chk("idle ticks", r, 0);
    @(posedge pclk);
    timer_input_pin[1] <= 1'b1;
    r = 0;
    repeat (20) @(negedge pclk) r += count_tick[1];
    chk("edge ticks", r, 1);
    // undivided clock with zero compare hides the request
    // prescaler rewritten with the channel stopped
    apb(1, `TPS_IDX_RUN, 16'h0);
    apb(1, regs[0], 16'h0);
    apb(1, `TPS_IDX_PRESC, 16'h0);
    apb(1, `TPS_IDX_RUN, 16'h1);
    @(posedge pclk);
    chan_irq_raw[0] <= 1'b1;
    repeat (3) @(negedge pclk);
    chk("masked irq", chan_irq_det[0], 1'b0);
    @(posedge pclk);
    channel_compare_value[15:0] <= 16'((($urandom % 16'hFFFF)) + 1);
    repeat (3) @(negedge pclk);
    chk("passed irq", chan_irq_det[0], 1'b1);
    // all channels enabled, then all stopped; flags follow the run bits
    apb(1, `TPS_IDX_RUN, 16'h000F);
    @(negedge pclk);
    chk("enable flags", channel_enabled_flag, 32'h0000000F);
    apb(1, `TPS_IDX_RUN, 16'h0000);
    @(negedge pclk);
    chk("stopped flags", channel_enabled_flag, 32'h00000000);
    give_verdict;
  end
endmodule // tb
